// ---- src/nsg_pkg.sv ----
// package for the noise-shaping and gain control block
// assumes a single 100 MHz clock and a plain register port
package nsg_pkg;
  localparam int CLK_MHZ = 100;
  // register map (byte addresses, one word each)
  localparam logic [7:0] NSG_ADDR_CTRL = 8'h00;
  localparam logic [7:0] NSG_ADDR_CORNER = 8'h04;
  localparam logic [7:0] NSG_ADDR_GAIN = 8'h08;
  localparam logic [7:0] NSG_ADDR_STATUS = 8'h0C;
  localparam logic [7:0] NSG_ADDR_FSCALE = 8'h10;
  localparam logic [7:0] NSG_ADDR_CENTER = 8'h14;
  // control fields
  localparam int CTRL_SHAPE_EN_BIT = 0;
  localparam int CTRL_EXT_REF_BIT = 1;
  // corner fields
  localparam int CORNER_LOW_LSB = 0;
  localparam int CORNER_HIGH_LSB = 4;
  localparam int CODE_W = 4;
  // gain fields
  localparam int GAIN_COARSE_BIT = 0;
  localparam int GAIN_FINE_LSB = 4;
  localparam logic [3:0] FINE_MAX = 4'hC;
  // status fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_LAT_LSB = 4;
  // timing in sample clock cycles
  localparam logic [4:0] LAT_OFF = 5'h0E;
  localparam logic [4:0] LAT_ON = 5'h0F;
  localparam logic [2:0] ON_DELAY = 3'h4;
  localparam logic [2:0] OFF_DELAY = 3'h1;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CORNER_RST = 32'h0000_0000;
  localparam logic [31:0] GAIN_RST = 32'h0000_0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // full scale in centivolts for 0 dB, 3.5 dB coarse
  localparam logic [7:0] FS_0DB = 8'hC8;
  localparam logic [7:0] FS_COARSE = 8'h86;
  localparam logic [1:0] CFG_ONEHOT_W = 2'h3;

  typedef enum logic [2:0] {
    NSG_OFF = 3'b001,
    NSG_ARM = 3'b010,
    NSG_ON = 3'b100
  } nsg_state_t;
endpackage

// ---- src/nsg_corner_lut.sv ----
// corner code to normalized corner frequency, in thousandths of fs
// purely combinational; the main block registers the result
`timescale 1ns/1ps
module nsg_corner_lut
  import nsg_pkg::*;
(
  input wire logic [3:0] code,
  output logic [9:0] milli
);
  // upper half of code space covers the low corners
  always_comb begin
    case (code)
      4'h0: milli = 10'h0FA;
      4'h1: milli = 10'h10E;
      4'h2: milli = 10'h122;
      4'h3: milli = 10'h137;
      4'h4: milli = 10'h14D;
      4'h5: milli = 10'h165;
      4'h6: milli = 10'h181;
      4'h7: milli = 10'h1A4;
      4'h8: milli = 10'h000;
      4'h9: milli = 10'h050;
      4'hA: milli = 10'h073;
      4'hB: milli = 10'h08F;
      4'hC: milli = 10'h0A7;
      4'hD: milli = 10'h0BD;
      4'hE: milli = 10'h0D2;
      default: milli = 10'h0E6;
    endcase
  end
endmodule

// ---- src/nsg_ctrl.sv ----
// noise-shaping, gain and reference-mode control for the converter
// assumes a synchronous register port, one clock, sample clock = mclk
// Contract
// - shaping off after reset, on by bit
// - latency 15 when shaping, else 14
// - on takes effect 4 cycles after write
// - off takes effect one cycle later
// - corner codes map to normalized corners
// - band center is mean of corners
// - shaping adds one cycle of latency
// - gain 0 dB after reset
// - coarse gain fixed 3.5 dB bit
// - fine gain 0 to 6 dB, 0.5 steps
// - full scale scales with gain
// - reference select, common-mode pin direction
`timescale 1ns/1ps
module nsg_ctrl
  import nsg_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic shape_active,
  output logic [4:0] latency,
  output logic [3:0] shaping_corner_code_low,
  output logic [3:0] shaping_corner_code_high,
  output logic [9:0] center_milli,
  output logic coarse_gain_on,
  output logic [3:0] fine_gain_code,
  output logic [7:0] full_scale_cv,
  output logic ext_ref,
  output logic common_mode_pin_oe
);

  typedef struct packed {
    nsg_state_t st;
    logic [2:0] cnt;
    logic en_req;
    logic ext_ref;
    logic [3:0] cor_lo;
    logic [3:0] cor_hi;
    logic coarse;
    logic [3:0] fine;
    logic active;
    logic [4:0] lat;
    logic [9:0] center;
    logic [7:0] fscale;
    logic cm_oe;
    logic [31:0] rdata;
  } nsg_regs_t;

  nsg_regs_t s_r;
  nsg_regs_t s_nxt;
  logic [9:0] lo_milli;
  logic [9:0] hi_milli;

  // full-scale range per gain step in centivolts
  function automatic logic [7:0] fine_fs(input logic [3:0] f);
    case (f)
      4'h0: fine_fs = FS_0DB;
      4'h1: fine_fs = 8'hBD;
      4'h2: fine_fs = 8'hB2;
      4'h3: fine_fs = 8'hA8;
      4'h4: fine_fs = 8'h9F;
      4'h5: fine_fs = 8'h96;
      4'h6: fine_fs = 8'h8E;
      4'h7: fine_fs = 8'h86;
      4'h8: fine_fs = 8'h7E;
      4'h9: fine_fs = 8'h77;
      4'hA: fine_fs = 8'h70;
      4'hB: fine_fs = 8'h6A;
      default: fine_fs = 8'h64;
    endcase
  endfunction

  // out-of-range fine codes are clamped to 6 dB
  function automatic logic [3:0] clamp_fine(input logic [3:0] f);
    clamp_fine = (f > FINE_MAX) ? FINE_MAX : f;
  endfunction

  nsg_corner_lut u_lut_lo (
    .code(s_r.cor_lo),
    .milli(lo_milli)
  );

  nsg_corner_lut u_lut_hi (
    .code(s_r.cor_hi),
    .milli(hi_milli)
  );

  always_comb begin
    logic [10:0] sum;
    logic wr_ctrl;
    sum = 11'h000;
    wr_ctrl = 1'b0;
    s_nxt = s_r;
    wr_ctrl = reg_wr && (reg_addr == NSG_ADDR_CTRL);
    // register writes; corners and the enable sit at different addresses, never in one write cycle
    if (wr_ctrl) begin
      s_nxt.en_req = reg_wdata[CTRL_SHAPE_EN_BIT];
      s_nxt.ext_ref = reg_wdata[CTRL_EXT_REF_BIT];
    end
    if (reg_wr && (reg_addr == NSG_ADDR_CORNER)) begin
      s_nxt.cor_lo = reg_wdata[CORNER_LOW_LSB +: CODE_W];
      s_nxt.cor_hi = reg_wdata[CORNER_HIGH_LSB +: CODE_W];
    end
    if (reg_wr && (reg_addr == NSG_ADDR_GAIN)) begin
      s_nxt.coarse = reg_wdata[GAIN_COARSE_BIT];
      s_nxt.fine = clamp_fine(reg_wdata[GAIN_FINE_LSB +: CODE_W]);
    end
    // activation sequencer; the write cycle stands for the 16th shift edge
    case (s_r.st)
      NSG_OFF: begin
        if (wr_ctrl && reg_wdata[CTRL_SHAPE_EN_BIT]) begin
          s_nxt.st = NSG_ARM;
          // full count: one step per edge, so the mode lands on the fourth edge after the write
          s_nxt.cnt = ON_DELAY;
        end
      end
      NSG_ARM: begin
        if (wr_ctrl && !reg_wdata[CTRL_SHAPE_EN_BIT]) begin
          s_nxt.st = NSG_OFF;
        end else if (s_r.cnt == OFF_DELAY) begin
          s_nxt.st = NSG_ON;
          s_nxt.active = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - OFF_DELAY;
        end
      end
      NSG_ON: begin
        if (wr_ctrl && !reg_wdata[CTRL_SHAPE_EN_BIT]) begin
          s_nxt.st = NSG_OFF;
          s_nxt.active = 1'b0;
        end
      end
      default: begin
        s_nxt.st = NSG_OFF;
        s_nxt.active = 1'b0;
      end
    endcase
    // only latency changes with the mode, no extra delay stage
    s_nxt.lat = s_nxt.active ? LAT_ON : LAT_OFF;
    // band center in thousandths of fs
    sum = {1'b0, lo_milli} + {1'b0, hi_milli};
    s_nxt.center = sum[10:1];
    // coarse setting overrides the fine table
    s_nxt.fscale = s_nxt.coarse ? FS_COARSE : fine_fs(s_nxt.fine);
    // common-mode pin is an input in external mode
    s_nxt.cm_oe = !s_nxt.ext_ref;
    // read data valid only in the cycle after the strobe
    s_nxt.rdata = RD_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        NSG_ADDR_CTRL: begin
          s_nxt.rdata[CTRL_SHAPE_EN_BIT] = s_r.en_req;
          s_nxt.rdata[CTRL_EXT_REF_BIT] = s_r.ext_ref;
        end
        NSG_ADDR_CORNER: begin
          s_nxt.rdata[CORNER_LOW_LSB +: CODE_W] = s_r.cor_lo;
          s_nxt.rdata[CORNER_HIGH_LSB +: CODE_W] = s_r.cor_hi;
        end
        NSG_ADDR_GAIN: begin
          s_nxt.rdata[GAIN_COARSE_BIT] = s_r.coarse;
          s_nxt.rdata[GAIN_FINE_LSB +: CODE_W] = s_r.fine;
        end
        NSG_ADDR_STATUS: begin
          s_nxt.rdata[STAT_ACTIVE_BIT] = s_r.active;
          s_nxt.rdata[STAT_PEND_BIT] = (s_r.st == NSG_ARM);
          s_nxt.rdata[STAT_LAT_LSB +: 5] = s_r.lat;
        end
        NSG_ADDR_FSCALE: s_nxt.rdata[7:0] = s_r.fscale;
        NSG_ADDR_CENTER: s_nxt.rdata[9:0] = s_r.center;
        default: s_nxt.rdata = RD_ZERO; // unmapped reads zero
      endcase
    end
  end

  // all state in one register; reset gives shaping off, 0 dB
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_r.st <= NSG_OFF;
      s_r.cnt <= 3'h0;
      s_r.en_req <= CTRL_RST[CTRL_SHAPE_EN_BIT];
      s_r.ext_ref <= CTRL_RST[CTRL_EXT_REF_BIT];
      s_r.cor_lo <= CORNER_RST[3:0];
      s_r.cor_hi <= CORNER_RST[7:4];
      s_r.coarse <= GAIN_RST[GAIN_COARSE_BIT];
      s_r.fine <= GAIN_RST[7:4];
      s_r.active <= 1'b0;
      s_r.lat <= LAT_OFF;
      s_r.center <= 10'h0FA;
      s_r.fscale <= FS_0DB;
      s_r.cm_oe <= 1'b1;
      s_r.rdata <= RD_ZERO;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign shape_active = s_r.active;
  assign latency = s_r.lat;
  assign shaping_corner_code_low = s_r.cor_lo;
  assign shaping_corner_code_high = s_r.cor_hi;
  assign center_milli = s_r.center;
  assign coarse_gain_on = s_r.coarse;
  assign fine_gain_code = s_r.fine;
  assign full_scale_cv = s_r.fscale;
  assign ext_ref = s_r.ext_ref;
  assign common_mode_pin_oe = s_r.cm_oe;
endmodule

// ---- verif/nsg_ctrl_assertions.sv ----
// port checker for the shaping and gain control block
// bound to nsg_ctrl; sees only its ports, one clock domain
`timescale 1ns/1ps
module nsg_ctrl_assertions
  import nsg_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic shape_active,
  input wire logic [4:0] latency,
  input wire logic [3:0] shaping_corner_code_low,
  input wire logic [3:0] shaping_corner_code_high,
  input wire logic coarse_gain_on,
  input wire logic [3:0] fine_gain_code,
  input wire logic [7:0] full_scale_cv,
  input wire logic ext_ref,
  input wire logic common_mode_pin_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // control-register write seen on the port
  wire logic ctl_wr = reg_wr && reg_addr == NSG_ADDR_CTRL;
  a_rst_state: assert property ($fell(sys_rst) |-> !shape_active && !coarse_gain_on && fine_gain_code == 4'h0)
    else $error("state after reset wrong");
  a_lat_track: assert property (latency == (shape_active ? LAT_ON : LAT_OFF))
    else $error("latency does not follow mode");
  a_on_delay: assert property ($rose(shape_active) |-> $past(ctl_wr && reg_wdata[0], 5))
    else $error("shaping came on at wrong time");
  a_on_hold: assert property (ctl_wr && reg_wdata[0] ##1 !ctl_wr [*4] |=> shape_active)
    else $error("shaping not on after enable");
  a_off_delay: assert property (ctl_wr && !reg_wdata[0] && shape_active |-> ##1 !shape_active)
    else $error("shaping not off after disable");
  a_status_rd: assert property ($past(reg_rd && reg_addr == NSG_ADDR_STATUS) |-> reg_rdata[8:4] == $past(latency))
    else $error("status latency read wrong");
  a_corner_wr: assert property (reg_wr && reg_addr == NSG_ADDR_CORNER |=>
    {shaping_corner_code_high, shaping_corner_code_low} == $past(reg_wdata[7:0]))
    else $error("corner codes not taken");
  a_fine_clamp: assert property (reg_wr && reg_addr == NSG_ADDR_GAIN |=>
    fine_gain_code == ($past(reg_wdata[7:4]) > FINE_MAX ? FINE_MAX : $past(reg_wdata[7:4])))
    else $error("fine gain not clamped");
  a_coarse_fs: assert property (coarse_gain_on && $stable(coarse_gain_on) |-> full_scale_cv == FS_COARSE)
    else $error("coarse full scale wrong");
  a_cm_dir: assert property ($stable(ext_ref) |-> common_mode_pin_oe == !ext_ref)
    else $error("common-mode pin direction wrong");
endmodule
bind nsg_ctrl nsg_ctrl_assertions chk_u (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .shape_active, .latency, .shaping_corner_code_low, .shaping_corner_code_high,
  .coarse_gain_on, .fine_gain_code, .full_scale_cv, .ext_ref, .common_mode_pin_oe);

// ---- verif/nsg_host_model.sv ----
// host model driving the register port
// assumes one clock; every change by nba right after a rising edge
`timescale 1ns/1ps
module nsg_host_model (
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr = 8'hFF;
    reg_wdata = 32'hFFFF_FFFF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // idle lines go inverted so the design never leans on stale values
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ---- verif/nsg_ctrl_tb_top.sv ----
// self-checking bench for the shaping and gain control block
// assumes the host model drives the register port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module nsg_ctrl_tb_top
  import nsg_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic shape_active;
  logic [4:0] latency;
  logic [3:0] shaping_corner_code_low;
  logic [3:0] shaping_corner_code_high;
  logic [9:0] center_milli;
  logic coarse_gain_on;
  logic [3:0] fine_gain_code;
  logic [7:0] full_scale_cv;
  logic ext_ref;
  logic common_mode_pin_oe;
  int err_total = 0;
  int check_count = 0;
  // corners in thousandths of fs, full scale in centivolts per half dB
  logic [9:0] corner_tbl [16] = '{10'h0FA, 10'h10E, 10'h122, 10'h137, 10'h14D, 10'h165, 10'h181, 10'h1A4,
    10'h000, 10'h050, 10'h073, 10'h08F, 10'h0A7, 10'h0BD, 10'h0D2, 10'h0E6};
  logic [7:0] fs_tbl [13] = '{8'hC8, 8'hBD, 8'hB2, 8'hA8, 8'h9F, 8'h96, 8'h8E, 8'h86, 8'h7E, 8'h77,
    8'h70, 8'h6A, 8'h64};
  always #5 mclk = ~mclk;
  nsg_ctrl dut_u (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .shape_active,
    .latency, .shaping_corner_code_low, .shaping_corner_code_high, .center_milli, .coarse_gain_on,
    .fine_gain_code, .full_scale_cv, .ext_ref, .common_mode_pin_oe);
  nsg_host_model host_u (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // generous wait so one-cycle config latency never decides the outcome
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // counts edges after a write until the mode reaches lvl, bounded
  task automatic count_to(input logic lvl, output int n);
    n = 0;
    while (shape_active !== lvl) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 10) begin
        err_total++;
        report_and_stop();
      end
    end
  endtask
  task automatic t_reset();
    logic [31:0] d;
    host_u.rd(NSG_ADDR_STATUS, d);
    `CHK("status", 32'h0000_00E0, d)
    `CHK("fine", 4'h0, fine_gain_code)
    `CHK("fscale", 8'hC8, full_scale_cv)
    `CHK("cm_oe", 1'b1, common_mode_pin_oe)
    `CHK("coarse", 1'b0, coarse_gain_on)
    `CHK("center", 10'h0FA, center_milli)
    `CHK("ext", 1'b0, ext_ref)
    // read data must drop back to zero once its one cycle has passed
    @(posedge mclk);
    #1;
    `CHK("rdata drop", 32'h0000_0000, reg_rdata)
    $display("test reset done");
  endtask
  task automatic t_corner();
    for (int c = 0; c < 16; c++) begin
      host_u.wr(NSG_ADDR_CORNER, {24'h0, c[3:0], c[3:0]});
      settle();
      `CHK("code", c[3:0], shaping_corner_code_high)
      `CHK("code lo", c[3:0], shaping_corner_code_low)
      `CHK("center", corner_tbl[c], center_milli)
    end
    host_u.wr(NSG_ADDR_CORNER, 32'h0000_00BD);
    settle();
    `CHK("center mix", 10'h0A6, center_milli)
    $display("test corner done");
  endtask
  task automatic t_shape();
    int n;
    logic [31:0] d;
    host_u.wr(NSG_ADDR_CTRL, 32'h0000_0001); // corners already set
    count_to(1'b1, n);
    `CHK("on delay", 4, n)
    host_u.rd(NSG_ADDR_STATUS, d);
    `CHK("status on", 32'h0000_00F1, d)
    host_u.wr(NSG_ADDR_CTRL, 32'h0000_0000);
    count_to(1'b0, n);
    `CHK("off delay", 1, n)
    `CHK("lat off", 5'h0E, latency)
    host_u.wr(NSG_ADDR_CTRL, 32'h0000_0001);
    host_u.rd(NSG_ADDR_STATUS, d);
    `CHK("status pend", 32'h0000_00E2, d)
    host_u.wr(NSG_ADDR_CTRL, 32'h0000_0000);
    repeat (8) @(posedge mclk);
    #1;
    `CHK("cancel", 1'b0, shape_active)
    $display("test shape done");
  endtask
  task automatic t_gain();
    int m;
    for (int c = 0; c < 16; c++) begin
      m = (c > 12) ? 12 : c;
      host_u.wr(NSG_ADDR_GAIN, {24'h0, c[3:0], 4'h0});
      settle();
      `CHK("fine", m[3:0], fine_gain_code)
      `CHK("fscale", fs_tbl[m], full_scale_cv)
    end
    host_u.wr(NSG_ADDR_GAIN, 32'h0000_0001);
    settle();
    `CHK("coarse", 1'b1, coarse_gain_on)
    `CHK("fs coarse", 8'h86, full_scale_cv)
    $display("test gain done");
  endtask
  task automatic t_ref();
    logic [31:0] d;
    host_u.wr(NSG_ADDR_CTRL, 32'h0000_0002);
    settle();
    `CHK("ext", 1'b1, ext_ref)
    `CHK("cm_oe", 1'b0, common_mode_pin_oe)
    host_u.rd(8'h3C, d);
    `CHK("unmapped", 32'h0000_0000, d)
    $display("test ref done");
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_corner();
    t_shape();
    t_gain();
    t_ref();
    report_and_stop();
  end
endmodule
